// *** hw/itb_talker.sv ***
`timescale 1ns/1ps
`default_nettype none
module itb_talker (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_soft_rst,
    input  wire logic       i_atn,
    input  wire logic       i_ifc,
    input  wire logic [7:0] i_bus_data,
    input  wire logic       i_cmd_accepted,
    input  wire logic       i_ready_for_byte_pin,
    input  wire logic       i_accepted_pin,
    input  wire logic [4:0] i_my_addr,
    input  wire logic [4:0] i_my_secondary,
    input  wire logic       i_talk_addr_low_bit_ignore,
    input  wire logic       i_listen_addr_low_bit_ignore,
    input  wire logic       i_ext_talker_en,
    input  wire logic       i_disable_talker,
    input  wire logic       i_talk_only,
    input  wire logic       i_auto_unaddr,
    input  wire logic       i_pp_write,
    input  wire logic [7:0] i_pp_word,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    input  wire logic [7:0] i_status_byte,
    output logic            o_tx_ready,
    output logic            o_data_valid_pin,
    output logic [7:0]      o_dio,
    output logic            o_dio_oe,
    output logic            o_talker_idle_state,
    output logic            o_talker_addressed_state,
    output logic            o_talker_active_state,
    output logic            o_serial_poll_active_state,
    output logic            o_serial_poll_idle_state,
    output logic            o_listen_addr_match,
    output logic            o_pp_configured,
    output logic [7:0]      o_pp_config,
    output logic            o_hs_error,
    output logic            o_pon
);
    import itb_pkg::*;

    // ========================================
    // pin synchronisers
    // only the second stage feeds logic, against metastability
    logic [4:0] s1_ff;
    logic [4:0] s2_ff;
    always_ff @(posedge i_clock) begin
        s1_ff <= {i_atn, i_ifc, i_cmd_accepted,
                  i_ready_for_byte_pin, i_accepted_pin};
        s2_ff <= s1_ff;
    end
    logic atn, ifc, cmd_acc, ready_for_byte_pin, dac;
    assign atn     = s2_ff[4];
    assign ifc     = s2_ff[3];
    assign cmd_acc = s2_ff[2];
    assign ready_for_byte_pin     = s2_ff[1];     // high means ready
    assign dac     = s2_ff[0];     // high means accepted

    // ========================================
    // power-on term
    logic pon;
    assign pon   = i_sys_rst | i_soft_rst;
    assign o_pon = pon;
    // the processor must drop i_soft_rst after reset; until then all stays idle

    // ========================================
    // address decode
    function automatic logic addr_eq(input logic [4:0] a,
                                     input logic [4:0] b,
                                     input logic       ign);
        logic [4:0] m;
        m = {4'hF, ~ign};
        addr_eq = ((a ^ b) & m) == 5'h00;
    endfunction : addr_eq

    logic cmd_new_ff;
    logic cmd_ev;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cmd_new_ff <= 1'b0;
        end else begin
            cmd_new_ff <= cmd_acc;
        end
    end
    // one command per accepted byte, only under attention
    assign cmd_ev = cmd_acc & ~cmd_new_ff & atn;

    logic [1:0] grp;
    logic [4:0] adr;
    assign grp = i_bus_data[6:5];
    assign adr = i_bus_data[4:0];

    logic mta, ota, mla, msa, spe, spd;
    logic is_listen, is_talk;
    logic own_listen, own_talk;

    always_comb begin
        is_listen  = grp == GRP_LISTEN;
        is_talk    = grp == GRP_TALK;
        own_listen = addr_eq(adr, i_my_addr,
                             i_listen_addr_low_bit_ignore);
        own_talk   = addr_eq(adr, i_my_addr,
                             i_talk_addr_low_bit_ignore);
        mla        = cmd_ev & is_listen & own_listen;
        mta        = cmd_ev & is_talk & own_talk;
        // any other talk address, untalk included, is another talker
        ota        = cmd_ev & is_talk & ~own_talk;
        // own listen address unaddresses the talker when asked
        if (i_auto_unaddr & mla) begin
            ota = 1'b1;
        end
        spe        = cmd_ev & (i_bus_data[6:0] == CMD_SPE);
        spd        = cmd_ev & (i_bus_data[6:0] == CMD_SPD);
    end

    assign o_listen_addr_match = mla;

    // extended path: primary match arms, matching secondary addresses
    logic prim_ff;
    always_ff @(posedge i_clock) begin
        if (pon | ifc) begin
            prim_ff <= 1'b0;
        end else if (cmd_ev) begin
            prim_ff <= mta & i_ext_talker_en;
        end
    end
    assign msa = cmd_ev & prim_ff & grp == GRP_SECOND &
                 adr == i_my_secondary;

    // ========================================
    // talker states
    itb_talk_t t_ff;
    itb_talk_t nxt_t;
    logic addr_hit;
    assign addr_hit = i_ext_talker_en ? msa : mta;

    always_comb begin
        nxt_t = t_ff;
        unique case (t_ff)
            TALKER_IDLE_STATE: begin
                if (addr_hit | i_talk_only) begin
                    nxt_t = TALKER_ADDRESSED_STATE;
                end
            end
            TALKER_ADDRESSED_STATE: begin
                if (ota) begin
                    nxt_t = TALKER_IDLE_STATE;
                end else if (~atn) begin
                    nxt_t = TALKER_ACTIVE_STATE;
                end
            end
            TALKER_ACTIVE_STATE: begin
                if (atn) begin
                    nxt_t = TALKER_ADDRESSED_STATE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (pon | ifc | i_disable_talker) begin
            t_ff <= TALKER_IDLE_STATE;
        end else begin
            t_ff <= nxt_t;
        end
    end

    // ========================================
    // serial poll mode
    // enable and disable are distinct bytes, never in one cycle
    logic spm_ff;
    always_ff @(posedge i_clock) begin
        if (pon | ifc | i_disable_talker) begin
            spm_ff <= 1'b0;
        end else if (spe) begin
            spm_ff <= 1'b1;
        end else if (spd) begin
            spm_ff <= 1'b0;
        end
    end

    // ========================================
    // state outputs
    logic talker_active_state, serial_poll_active_state;
    assign talker_active_state = (t_ff == TALKER_ACTIVE_STATE) & ~spm_ff;
    assign serial_poll_active_state = (t_ff == TALKER_ACTIVE_STATE) & spm_ff;
    assign o_talker_idle_state        = t_ff == TALKER_IDLE_STATE;
    assign o_talker_addressed_state   = t_ff == TALKER_ADDRESSED_STATE;
    assign o_talker_active_state      = talker_active_state;
    assign o_serial_poll_active_state = serial_poll_active_state;
    assign o_serial_poll_idle_state   = ~serial_poll_active_state;

    // ========================================
    // parallel poll configure
    logic [7:0] pp_ff;
    logic       ppc_ff;
    always_ff @(posedge i_clock) begin
        if (pon) begin
            pp_ff <= PP_RST;
        end else if (i_pp_write) begin
            pp_ff <= i_pp_word;
        end
    end

    always_ff @(posedge i_clock) begin
        if (pon) begin
            ppc_ff <= 1'b0;
        end else if (i_pp_write) begin
            ppc_ff <= i_pp_word != PP_UNCONFIG;
        end
    end
    assign o_pp_config     = pp_ff;
    assign o_pp_configured = ppc_ff;

    // ========================================
    // source handshake
    // ready and accepted arrive already wired-AND across listeners
    itb_src_t   sh_ff;
    itb_src_t   nxt_sh;
    logic [7:0] dio_ff;
    logic       dav_ff;
    logic       err_ff;
    logic       can_src;
    logic       src_go;
    logic       src_done;
    logic       src_clr;

    assign can_src  = talker_active_state | serial_poll_active_state;
    // a byte starts only when acceptors are ready and none still accepts
    assign src_go   = can_src & ready_for_byte_pin & ~dac & (serial_poll_active_state | i_tx_valid);
    // attention aborts the wait so the controller can take the bus
    assign src_done = dac | atn;
    // a disabled talker must not leave a byte marked valid
    assign src_clr  = pon | ifc | i_disable_talker;
    assign o_tx_ready = (sh_ff == SH_IDLE) & talker_active_state & ready_for_byte_pin & ~dac;

    always_comb begin
        nxt_sh = sh_ff;
        unique case (sh_ff)
            SH_IDLE: begin
                if (src_go) begin
                    nxt_sh = SH_VALID;
                end
            end
            SH_VALID: begin
                // data settles a cycle before valid is raised
                nxt_sh = SH_WAIT;
            end
            SH_WAIT: begin
                if (src_done) begin
                    nxt_sh = SH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (src_clr) begin
            sh_ff <= SH_IDLE;
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    always_ff @(posedge i_clock) begin
        if (src_clr) begin
            dio_ff <= 8'h00;
        end else if ((sh_ff == SH_IDLE) && src_go) begin
            dio_ff <= serial_poll_active_state ? i_status_byte : i_tx_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (src_clr) begin
            dav_ff <= 1'b0;
        end else if (sh_ff == SH_VALID) begin
            dav_ff <= 1'b1;
        end else if ((sh_ff == SH_WAIT) && src_done) begin
            dav_ff <= 1'b0;
        end
    end
    assign o_data_valid_pin = dav_ff;
    assign o_dio            = dio_ff;
    assign o_dio_oe         = can_src;


    // ========================================
    // handshake error
    // both lines high while talker or poll active means no acceptor drives them: flag, keep going
    always_ff @(posedge i_clock) begin
        if (pon) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= can_src & ready_for_byte_pin & dac;
        end
    end
    assign o_hs_error = err_ff;
endmodule : itb_talker
`default_nettype wire

// *** hw/itb_pkg.sv ***
// How it works
// - power-on puts talker and poll idle
// - interface clear or disable-talker forces idle
// - own talk address under attention addresses talker
// - extended enable uses primary plus secondary addressing
// - talk low-bit-ignore accepts two talk addresses
// - listen low-bit-ignore accepts two listen addresses
// - addressed becomes active when attention drops
// - attention true returns active to addressed
// - serial poll enable enters poll-active instead of talker-active once attention drops
// - no data bytes while serial poll enabled
// - talk-only goes through addressed into active
// - other talk address unaddresses the talker
// - own listen address unaddresses the talker
// - power-on is reset pin or software reset
// - poll word write configures, zero write unconfigures
// - ready and accepted pins are positive logic
// - acceptor lines combine as logical AND
// - release data valid only after all accepted or attention true
// - ready and accepted both high is error; flagged only while talker or poll active
package itb_pkg;
    // ========================================
    // command coding
    localparam logic [1:0] GRP_LISTEN   = 2'h1;
    localparam logic [1:0] GRP_TALK     = 2'h2;
    localparam logic [1:0] GRP_SECOND   = 2'h3;
    localparam logic [6:0] CMD_SPE      = 7'h18;
    localparam logic [6:0] CMD_SPD      = 7'h19;
    localparam logic [4:0] ADDR_UNADDR  = 5'h1F;
    localparam logic [4:0] ADDR_RST     = 5'h00;
    localparam logic [7:0] PP_UNCONFIG  = 8'h00;
    localparam logic [7:0] PP_RST       = 8'h00;
    localparam int         ADDR_LSB_POS = 0;

    typedef enum logic [2:0] {
        TALKER_IDLE_STATE      = 3'b001,
        TALKER_ADDRESSED_STATE = 3'b010,
        TALKER_ACTIVE_STATE    = 3'b100
    } itb_talk_t;

    typedef enum logic [2:0] {
        SH_IDLE  = 3'b001,
        SH_VALID = 3'b010,
        SH_WAIT  = 3'b100
    } itb_src_t;
endpackage : itb_pkg

// *** dv/itb_talker_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// talker port checker
module itb_talker_monitor (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_soft_rst,
    input wire logic i_atn,
    input wire logic i_ifc,
    input wire logic i_disable_talker,
    input wire logic i_accepted_pin,
    input wire logic o_tx_ready,
    input wire logic o_data_valid_pin,
    input wire logic o_dio_oe,
    input wire logic o_talker_idle_state,
    input wire logic o_talker_addressed_state,
    input wire logic o_talker_active_state,
    input wire logic o_serial_poll_active_state,
    input wire logic o_pon
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // pins pass two sync stages, so hold them four edges
    sequence s_ifc_held; i_ifc [*4]; endsequence
    sequence s_atn_held; i_atn [*4]; endsequence
    a_idle_after_pon: assert property ($past(o_pon) |->
        o_talker_idle_state && !o_serial_poll_active_state)
        else $error("talker not idle after reset");
    a_pon_soft_or: assert property (o_pon == i_soft_rst)
        else $error("power-on term wrong");
    a_ifc_to_idle: assert property (s_ifc_held |=>
        o_talker_idle_state) else $error("clear did not idle");
    a_dat_to_idle: assert property (i_disable_talker [*3] |=>
        o_talker_idle_state) else $error("disable did not idle");
    a_atn_stops_active: assert property (s_atn_held |=>
        !o_talker_active_state) else $error("active under atn");
    a_active_via_addr: assert property ($rose(o_talker_active_state)
        |-> $past(o_talker_addressed_state))
        else $error("active not reached from addressed");
    a_drive_only_active: assert property (o_dio_oe ||
        o_data_valid_pin |-> o_talker_active_state ||
        o_serial_poll_active_state)
        else $error("drives data while not active");
    a_poll_no_data: assert property (o_serial_poll_active_state
        |-> !o_tx_ready) else $error("data taken in poll");
    a_dav_after_dac: assert property ($fell(o_data_valid_pin) |->
        $past(i_accepted_pin) || $past(i_atn) || $past(o_pon)
        || $past(i_ifc) || $past(i_disable_talker))
        else $error("valid dropped before accepted");
endmodule : itb_talker_monitor
bind itb_talker itb_talker_monitor u_mon (.i_clock, .i_sys_rst,
    .i_soft_rst, .i_atn, .i_ifc, .i_disable_talker, .i_accepted_pin,
    .o_tx_ready, .o_data_valid_pin, .o_dio_oe, .o_talker_idle_state,
    .o_talker_addressed_state, .o_talker_active_state,
    .o_serial_poll_active_state, .o_pon);
`default_nettype wire

// *** dv/itb_acceptor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// listeners seen as one acceptor
module itb_acceptor_model (
    input  wire logic       i_clock,
    input  wire logic       i_dav,
    input  wire logic [3:0] i_delay,
    output logic            o_ready,
    output logic            o_accepted
);
    logic [3:0] cnt_ff = 4'h0;
    always_ff @(posedge i_clock) begin
        if (!i_dav) cnt_ff <= 4'h0;
        else if (cnt_ff != i_delay) cnt_ff <= cnt_ff + 4'h1;
    end
    // one model stands for all listeners, lines already combined
    // positive logic; never both high, so no error is provoked
    assign o_ready    = !i_dav;
    assign o_accepted = i_dav && (cnt_ff == i_delay);
endmodule : itb_acceptor_model
`default_nettype wire

// *** dv/itb_talker_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module itb_talker_tb;
    logic i_clock, i_sys_rst, i_soft_rst, i_atn, i_ifc, i_cmd_accepted;
    logic i_ready_for_byte_pin, i_accepted_pin, i_ext_talker_en;
    logic i_talk_addr_low_bit_ignore, i_listen_addr_low_bit_ignore;
    logic i_disable_talker, i_talk_only, i_auto_unaddr, i_pp_write;
    logic i_tx_valid, o_tx_ready, o_data_valid_pin, o_dio_oe, o_pon;
    logic o_talker_idle_state, o_talker_addressed_state, o_hs_error;
    logic o_talker_active_state, o_serial_poll_active_state;
    logic o_serial_poll_idle_state, o_listen_addr_match, o_pp_configured;
    logic [4:0] i_my_addr, i_my_secondary;
    logic [7:0] i_bus_data, i_pp_word, i_tx_data, i_status_byte;
    logic [7:0] o_dio, o_pp_config;
    logic [3:0] dly;
    int errors = 0, n_compared = 0;
    itb_talker dut (.*);
    itb_acceptor_model u_acc (.i_clock, .i_dav(o_data_valid_pin),
        .i_delay(dly), .o_ready(i_ready_for_byte_pin),
        .o_accepted(i_accepted_pin));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk
    // state code: idle 8, addressed 4, active 2, poll active 1
    task automatic st(input logic [3:0] e);
        chk({4'h0, o_talker_idle_state, o_talker_addressed_state,
            o_talker_active_state, o_serial_poll_active_state}, {4'h0, e});
    endtask : st
    task automatic cmd(input logic [7:0] b);
        i_bus_data = b;
        i_cmd_accepted = 1'b1;
        step(4);
        i_cmd_accepted = 1'b0;
        step(4);
    endtask : cmd
    task automatic results;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic send(input logic [7:0] d);
        int k;
        i_tx_data = d;
        i_tx_valid = 1'b1;
        for (k = 0; k < 20 && o_tx_ready !== 1'b1; k++) step(1);
        if (k == 20) begin
            errors++;
            results();
        end
        step(2);
        i_tx_valid = 1'b0;
        chk(o_dio, d);
        for (k = 0; k < 30 && o_data_valid_pin !== 1'b0; k++) step(1);
        if (k == 30) begin
            errors++;
            results();
        end
    endtask : send
    initial begin
        {i_sys_rst, i_soft_rst, i_atn, i_ifc, i_cmd_accepted} = 5'h10;
        {i_ext_talker_en, i_talk_addr_low_bit_ignore, i_talk_only} = 3'h0;
        {i_listen_addr_low_bit_ignore, i_disable_talker} = 2'h0;
        {i_auto_unaddr, i_pp_write, i_tx_valid} = 3'h0;
        {i_bus_data, i_pp_word, i_tx_data} = 24'h0;
        {i_my_addr, i_my_secondary, i_status_byte} = 18'h0AA5A;
        dly = 4'h3;
        step(10);
        i_sys_rst = 1'b0;
        step(3);
        st(4'h8);
        i_atn = 1'b1;
        cmd(8'h45);
        st(4'h4);
        i_atn = 1'b0;
        step(4);
        st(4'h2);
        send(8'hA5);
        dly = 4'h0;
        send(8'h3C);
        i_atn = 1'b1;
        step(5);
        st(4'h4);
        $display("test 1 done");
        cmd(8'h18);
        i_atn = 1'b0;
        i_tx_valid = 1'b1;
        step(5);
        st(4'h1);
        chk(o_dio, 8'h5A);
        chk(8'(o_serial_poll_idle_state), 8'h00);
        chk(8'(o_tx_ready), 8'h00);
        i_tx_valid = 1'b0;
        i_atn = 1'b1;
        cmd(8'h19);
        cmd(8'h46);
        st(4'h8);
        i_talk_addr_low_bit_ignore = 1'b1;
        cmd(8'h44);
        st(4'h4);
        {i_auto_unaddr, i_listen_addr_low_bit_ignore} = 2'h3;
        cmd(8'h24);
        st(4'h8);
        $display("test 2 done");
        cmd(8'h18);
        cmd(8'h45);
        i_atn = 1'b0;
        step(5);
        st(4'h1);
        i_atn = 1'b1;
        cmd(8'h19);
        i_ifc = 1'b1;
        step(5);
        st(4'h8);
        i_ifc = 1'b0;
        i_ext_talker_en = 1'b1;
        cmd(8'h45);
        cmd(8'h6A);
        st(4'h4);
        i_disable_talker = 1'b1;
        step(4);
        st(4'h8);
        {i_disable_talker, i_ext_talker_en, i_atn, i_talk_only} = 4'h1;
        step(6);
        st(4'h2);
        send(8'h81);
        i_soft_rst = 1'b1;
        step(2);
        chk(8'(o_pon), 8'h01);
        st(4'h8);
        {i_soft_rst, i_talk_only} = 2'h0;
        $display("test 3 done");
        for (int w = 0; w < 2; w++) begin
            i_pp_word = w ? 8'h00 : 8'h6B;
            i_pp_write = 1'b1;
            step(1);
            i_pp_write = 1'b0;
            step(1);
            chk(8'(o_pp_configured), w ? 8'h00 : 8'h01);
        end
        chk(o_pp_config, 8'h00);
        chk(8'(o_hs_error), 8'h00);
        $display("test 4 done");
        results();
    end
endmodule : itb_talker_tb
`default_nettype wire
